// ==== verilog/mcsb_pkg.sv ====
`default_nettype none
package mcsb_pkg;
   // sfr offsets in the direct address space
   localparam logic [7:0] SFR_BASE_ADDR  = 8'h80;
   localparam logic [7:0] ADDR_SP        = 8'h81;
   localparam logic [7:0] ADDR_DPL       = 8'h82;
   localparam logic [7:0] ADDR_DPH       = 8'h83;
   localparam logic [7:0] ADDR_POWER_CONTROL      = 8'h87;
   localparam logic [7:0] ADDR_CFG       = 8'hAF;
   localparam logic [7:0] ADDR_PSW       = 8'hD0;
   localparam logic [7:0] ADDR_ACC       = 8'hE0;
   localparam logic [7:0] ADDR_B         = 8'hF0;
   // working register banks sit below this address
   localparam logic [7:0] BANK_RAM_TOP   = 8'h20;
   localparam int         BANK_RAM_DEPTH = 32;
   localparam int         BANK_RAM_AW    = 5;
   localparam int         DATA_W         = 8;

   // values after reset
   localparam logic [7:0] RST_SP         = 8'h07;
   localparam logic [7:0] RST_DPL        = 8'h00;
   localparam logic [7:0] RST_DPH        = 8'h00;
   localparam logic [7:0] RST_POWER_CONTROL       = 8'h00;
   localparam logic [7:0] RST_CFG        = 8'h80;
   localparam logic [7:0] RST_PSW        = 8'h00;
   localparam logic [7:0] RST_ACC        = 8'h00;
   localparam logic [7:0] RST_B          = 8'h00;

   // status word bit positions
   localparam int PSW_CY  = 7;
   localparam int PSW_AC  = 6;
   localparam int PSW_F0  = 5;
   localparam int PSW_RSH = 4;
   localparam int PSW_RSL = 3;
   localparam int PSW_OV  = 2;
   localparam int PSW_F1  = 1;
   localparam int PSW_P   = 0;
   // configuration and power bit positions
   localparam int CFG_UART_ENH = 6;
   localparam int CFG_SYNC_SEL = 5;
   localparam int CFG_IR_MOD   = 4;
   localparam int CFG_XREN_HI  = 1;
   localparam int CFG_XREN_LO  = 0;
   localparam int POWER_CONTROL_BAUD2   = 7;

   // class of the instruction retiring flags
   typedef enum logic [2:0] {
      ALU_NONE  = 3'b000,
      ALU_ADD   = 3'b001,
      ALU_ADDC  = 3'b010,
      ALU_SUBB  = 3'b011,
      ALU_MUL   = 3'b100,
      ALU_DIV   = 3'b101,
      ALU_LOGIC = 3'b110
   } mcsb_alu_cls_t;

   // direct or indirect byte access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       direct;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mcsb_sfr_req_t;

   // single bit access to bit addressable sfrs
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic       wbit;
   } mcsb_bit_req_t;

   // flag results from the alu
   typedef struct packed {
      mcsb_alu_cls_t cls;
      logic          cy;
      logic          ac;
      logic          ov;
   } mcsb_alu_flags_t;

   // working register access by bank-relative index
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] idx;
      logic [7:0] wdata;
   } mcsb_reg_req_t;
endpackage : mcsb_pkg
`default_nettype wire

// ==== verilog/mcsb_bank_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsb_bank_ram #(
   parameter int DEPTH = 32,
   parameter int AW    = 5,
   parameter int DW    = 8
) (
   input  wire logic          CLK_SYS_I,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rdata_q;

   // contents are not reset, software owns them; read data is registered
   always_ff @(posedge CLK_SYS_I) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_q <= mem_q[addr_i];
   end

   assign rdata_o = rdata_q;
endmodule // mcsb_bank_ram
`default_nettype wire

// ==== verilog/mcsb_flag_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsb_flag_unit (
   input  wire logic                    cy_i,
   input  wire logic                    ac_i,
   input  wire logic                    ov_i,
   input  wire mcsb_pkg::mcsb_alu_flags_t alu_i,
   output logic                         cy_o,
   output logic                         ac_o,
   output logic                         ov_o
);
   import mcsb_pkg::*;

   // pick which flags the retiring instruction may touch
   always_comb begin
      cy_o = cy_i;
      ac_o = ac_i;
      ov_o = ov_i;
      unique case (alu_i.cls)
         ALU_ADD, ALU_ADDC: begin
            // RQ2: carry on add
            cy_o = alu_i.cy;
            // RQ3: half carry add only
            ac_o = alu_i.ac;
            // RQ6: overflow on add
            ov_o = alu_i.ov;
         end
         ALU_SUBB, ALU_MUL, ALU_DIV: begin
            // RQ2: carry on others
            cy_o = alu_i.cy;
            // RQ6: overflow on others
            ov_o = alu_i.ov;
         end
         ALU_NONE, ALU_LOGIC: begin
            cy_o = cy_i;
         end
         default: begin
            // illegal code leaves flags alone
            cy_o = cy_i;
         end
      endcase
   end
endmodule // mcsb_flag_unit
`default_nettype wire

// ==== verilog/mcsb_core_sfr.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: sfrs answer only direct accesses to addresses 0x80 and above.
// RQ2: carry is loaded by add, add with carry, subtract, multiply, divide.
// RQ3: half carry is loaded only by add and add with carry.
// RQ4: status bits 5 and 1 are plain user flags with no side effect.
// RQ5: status bits 4:3 pick working bank 0 to 3.
// RQ6: overflow is loaded by add, add with carry, subtract, mul and div.
// RQ7: status bit 0 is kept as even parity over the accumulator.
// RQ8: power byte resets to zero, bit 7 doubles the baud rate.
// RQ9: data pointer low and high bytes reset to zero and form 16 bits.
// RQ10: stack pointer holds eight bits and loads 7 at reset.
// RQ11: software keeps configuration bit 7 set.
// RQ12: configuration bit 6 turns on the enhanced uart checks.
// RQ13: configuration bit 5 hands the shared pins to i2c or spi.
// RQ14: configuration bit 4 gates the 38 kHz modulation.
// RQ15: either external ram enable bit lets the move reach 256 bytes.
// RQ16: the four working banks live in the lowest 32 bytes of ram.
// RQ17: configuration bits 3 and 2 store and read back, nothing more.
module mcsb_core_sfr (
   input  wire logic                      CLK_SYS_I,
   input  wire logic                      SRST_I,
   input  wire mcsb_pkg::mcsb_sfr_req_t   SFR_REQ_I,
   input  wire mcsb_pkg::mcsb_bit_req_t   BIT_REQ_I,
   input  wire mcsb_pkg::mcsb_alu_flags_t ALU_FLAGS_I,
   input  wire mcsb_pkg::mcsb_reg_req_t   REG_REQ_I,
   input  wire logic                      ACC_WE_I,
   input  wire logic [7:0]                ACC_WD_I,
   input  wire logic                      SP_INC_I,
   input  wire logic                      SP_DEC_I,
   input  wire logic                      DPTR_INC_I,
   input  wire logic                      DPTR_LD_I,
   input  wire logic [15:0]               DPTR_WD_I,
   input  wire logic                      XMOVE_REQ_I,
   output logic      [7:0]                RD_DATA_O,
   output logic                           RD_HIT_O,
   output logic                           BIT_RD_O,
   output logic      [7:0]                REG_RD_DATA_O,
   output logic      [7:0]                ACC_O,
   output logic      [7:0]                B_O,
   output logic      [7:0]                PSW_O,
   output logic      [1:0]                BANK_SEL_O,
   output logic      [15:0]               DPTR_O,
   output logic      [7:0]                SP_O,
   output logic                           BAUD_DOUBLE_O,
   output logic                           UART_ENH_O,
   output logic                           SYNC_PORT_SPI_O,
   output logic                           IR_MOD_EN_O,
   output logic                           XRAM_EN_O,
   output logic                           XMOVE_GRANT_O,
   output logic                           XMOVE_BLOCK_O
);
   import mcsb_pkg::*;

   // every register of the bank in one record
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] b;
      logic       cy;
      logic       ac;
      logic       f0;
      logic [1:0] rs;
      logic       ov;
      logic       f1;
      logic       par;
      logic [7:0] power_control;
      logic [7:0] data_pointer_low;
      logic [7:0] data_pointer_high;
      logic [7:0] sp;
      logic [7:0] cfg;
      logic       xram_en;
      logic [7:0] rdata;
      logic       hit;
      logic       bit_rd;
      logic       grant;
      logic       block;
   } mcsb_state_t;

   mcsb_state_t st_q;
   mcsb_state_t st_d;

   logic       flag_cy;
   logic       flag_ac;
   logic       flag_ov;
   logic       ram_we;
   logic [4:0] ram_addr;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;
   logic [7:0] psw_now;
   logic [7:0] bit_byte;
   logic [7:0] bit_base;
   logic       sfr_wr;
   logic       sfr_rd;
   logic       low_wr;
   logic       sw_cy;
   logic       sw_ac;
   logic       sw_ov;

   // one decode shared by byte and bit paths
   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] reg_addr);
      return a == reg_addr;
   endfunction

   // status byte assembled from its fields
   function automatic logic [7:0] pack_psw(input mcsb_state_t s);
      return {s.cy, s.ac, s.f0, s.rs, s.ov, s.f1, s.par};
   endfunction

   // RQ1: direct upper half only
   assign sfr_wr = SFR_REQ_I.wr & SFR_REQ_I.direct
                 & (SFR_REQ_I.addr >= SFR_BASE_ADDR);
   assign sfr_rd = SFR_REQ_I.rd & SFR_REQ_I.direct
                 & (SFR_REQ_I.addr >= SFR_BASE_ADDR);
   // low ram write may be direct or indirect
   assign low_wr = SFR_REQ_I.wr & (SFR_REQ_I.addr < BANK_RAM_TOP);

   assign psw_now  = pack_psw(st_q);
   assign bit_base = {BIT_REQ_I.addr[7:3], 3'h0};

   // byte holding the addressed bit, zero when not bit addressable
   always_comb begin
      bit_byte = 8'h00;
      if (is_reg(bit_base, ADDR_PSW)) begin
         bit_byte = psw_now;
      end else if (is_reg(bit_base, ADDR_ACC)) begin
         bit_byte = st_q.acc;
      end else if (is_reg(bit_base, ADDR_B)) begin
         bit_byte = st_q.b;
      end
   end

   // RQ16: bank index into low ram
   always_comb begin
      if (REG_REQ_I.wr | REG_REQ_I.rd) begin
         ram_addr  = {st_q.rs, REG_REQ_I.idx};
         ram_we    = REG_REQ_I.wr;
         ram_wdata = REG_REQ_I.wdata;
      end else begin
         ram_addr  = SFR_REQ_I.addr[4:0];
         ram_we    = low_wr;
         ram_wdata = SFR_REQ_I.wdata;
      end
   end

   mcsb_bank_ram #(
      .DEPTH (BANK_RAM_DEPTH),
      .AW    (BANK_RAM_AW),
      .DW    (DATA_W)
   ) u_bank_ram (
      .CLK_SYS_I (CLK_SYS_I),
      .we_i      (ram_we),
      .addr_i    (ram_addr),
      .wdata_i   (ram_wdata),
      .rdata_o   (ram_rdata)
   );

   // software view of the alu flags, kept apart so the merge has no loop
   always_comb begin
      sw_cy = st_q.cy;
      sw_ac = st_q.ac;
      sw_ov = st_q.ov;
      if (sfr_wr & is_reg(SFR_REQ_I.addr, ADDR_PSW)) begin
         sw_cy = SFR_REQ_I.wdata[PSW_CY];
         sw_ac = SFR_REQ_I.wdata[PSW_AC];
         sw_ov = SFR_REQ_I.wdata[PSW_OV];
      end
      // a bit write lands after the byte write
      if (BIT_REQ_I.wr & is_reg(bit_base, ADDR_PSW)) begin
         if (BIT_REQ_I.addr[2:0] == 3'(PSW_CY)) begin
            sw_cy = BIT_REQ_I.wbit;
         end
         if (BIT_REQ_I.addr[2:0] == 3'(PSW_AC)) begin
            sw_ac = BIT_REQ_I.wbit;
         end
         if (BIT_REQ_I.addr[2:0] == 3'(PSW_OV)) begin
            sw_ov = BIT_REQ_I.wbit;
         end
      end
   end

   // flag merge sees software writes first, so the alu wins a tie
   mcsb_flag_unit u_flag_unit (
      .cy_i  (sw_cy),
      .ac_i  (sw_ac),
      .ov_i  (sw_ov),
      .alu_i (ALU_FLAGS_I),
      .cy_o  (flag_cy),
      .ac_o  (flag_ac),
      .ov_o  (flag_ov)
   );

   // next state: byte write, then bit write, then core updates
   always_comb begin
      st_d = st_q;
      if (sfr_wr) begin
         unique case (SFR_REQ_I.addr)
            ADDR_ACC: st_d.acc = SFR_REQ_I.wdata;
            ADDR_B:   st_d.b   = SFR_REQ_I.wdata;
            ADDR_PSW: begin
               // RQ4: user flags just store
               st_d.f0 = SFR_REQ_I.wdata[PSW_F0];
               st_d.f1 = SFR_REQ_I.wdata[PSW_F1];
               st_d.cy = SFR_REQ_I.wdata[PSW_CY];
               st_d.ac = SFR_REQ_I.wdata[PSW_AC];
               st_d.ov = SFR_REQ_I.wdata[PSW_OV];
               // RQ5: bank select store
               st_d.rs = SFR_REQ_I.wdata[PSW_RSH:PSW_RSL];
            end
            // RQ8: power byte stored whole
            ADDR_POWER_CONTROL: st_d.power_control = SFR_REQ_I.wdata;
            // RQ9: pointer bytes separately
            ADDR_DPL:  st_d.data_pointer_low  = SFR_REQ_I.wdata;
            ADDR_DPH:  st_d.data_pointer_high  = SFR_REQ_I.wdata;
            // RQ10: stack pointer write
            ADDR_SP:   st_d.sp   = SFR_REQ_I.wdata;
            // RQ17: reserved bits simply kept
            ADDR_CFG:  st_d.cfg  = SFR_REQ_I.wdata;
            default:   st_d.cfg  = st_q.cfg;
         endcase
      end
      // bit writes touch only the three bit addressable registers
      if (BIT_REQ_I.wr) begin
         if (is_reg(bit_base, ADDR_ACC)) begin
            st_d.acc[BIT_REQ_I.addr[2:0]] = BIT_REQ_I.wbit;
         end else if (is_reg(bit_base, ADDR_B)) begin
            st_d.b[BIT_REQ_I.addr[2:0]] = BIT_REQ_I.wbit;
         end else if (is_reg(bit_base, ADDR_PSW)) begin
            unique case (BIT_REQ_I.addr[2:0])
               3'h7: st_d.cy    = BIT_REQ_I.wbit;
               3'h6: st_d.ac    = BIT_REQ_I.wbit;
               3'h5: st_d.f0    = BIT_REQ_I.wbit;
               3'h4: st_d.rs[1] = BIT_REQ_I.wbit;
               3'h3: st_d.rs[0] = BIT_REQ_I.wbit;
               3'h2: st_d.ov    = BIT_REQ_I.wbit;
               3'h1: st_d.f1    = BIT_REQ_I.wbit;
               // parity bit is hardware owned, write ignored
               3'h0: st_d.par   = st_q.par;
            endcase
         end
      end
      // alu result beats a software write in the same cycle
      if (ACC_WE_I) begin
         st_d.acc = ACC_WD_I;
      end
      if (ALU_FLAGS_I.cls != ALU_NONE) begin
         // RQ2: carry from flag unit
         st_d.cy = flag_cy;
         // RQ3: half carry from flag unit
         st_d.ac = flag_ac;
         // RQ6: overflow from flag unit
         st_d.ov = flag_ov;
      end
      // push and pop wrap within eight bits
      // RQ10: stack pointer stepping
      if (SP_INC_I & ~SP_DEC_I) begin
         st_d.sp = st_q.sp + 8'h01;
      end else if (SP_DEC_I & ~SP_INC_I) begin
         st_d.sp = st_q.sp - 8'h01;
      end
      // RQ9: sixteen bit pointer ops
      if (DPTR_LD_I) begin
         {st_d.data_pointer_high, st_d.data_pointer_low} = DPTR_WD_I;
      end else if (DPTR_INC_I) begin
         {st_d.data_pointer_high, st_d.data_pointer_low} = {st_q.data_pointer_high, st_q.data_pointer_low} + 16'h0001;
      end
      // RQ7: parity follows next accumulator
      st_d.par = ^st_d.acc;

      // registered read answer, unmapped reads return zero
      st_d.rdata = 8'h00;
      st_d.hit   = 1'b0;
      if (sfr_rd) begin
         st_d.hit = 1'b1;
         unique case (SFR_REQ_I.addr)
            ADDR_ACC:  st_d.rdata = st_q.acc;
            ADDR_B:    st_d.rdata = st_q.b;
            ADDR_PSW:  st_d.rdata = psw_now;
            ADDR_POWER_CONTROL: st_d.rdata = st_q.power_control;
            ADDR_DPL:  st_d.rdata = st_q.data_pointer_low;
            ADDR_DPH:  st_d.rdata = st_q.data_pointer_high;
            ADDR_SP:   st_d.rdata = st_q.sp;
            ADDR_CFG:  st_d.rdata = st_q.cfg;
            default:   st_d.hit   = 1'b0;
         endcase
      end
      st_d.bit_rd = BIT_REQ_I.rd & bit_byte[BIT_REQ_I.addr[2:0]];

      // RQ15: external move gate
      st_d.grant = XMOVE_REQ_I &
                   (st_q.cfg[CFG_XREN_HI] | st_q.cfg[CFG_XREN_LO]);
      st_d.block = XMOVE_REQ_I &
                   ~(st_q.cfg[CFG_XREN_HI] | st_q.cfg[CFG_XREN_LO]);
      // enable kept in its own flop so the output is registered
      st_d.xram_en = st_d.cfg[CFG_XREN_HI] | st_d.cfg[CFG_XREN_LO];
   end

   // synchronous reset loads documented defaults
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         st_q.acc    <= RST_ACC;
         st_q.b      <= RST_B;
         {st_q.cy, st_q.ac, st_q.f0, st_q.rs,
          st_q.ov, st_q.f1, st_q.par} <= RST_PSW;
         // RQ8: power byte cleared
         st_q.power_control   <= RST_POWER_CONTROL;
         // RQ9: pointer cleared
         st_q.data_pointer_low    <= RST_DPL;
         st_q.data_pointer_high    <= RST_DPH;
         // RQ10: stack pointer seven
         st_q.sp     <= RST_SP;
         // RQ11: bit 7 starts set
         st_q.cfg    <= RST_CFG;
         st_q.xram_en <= |RST_CFG[1:0];
         st_q.rdata  <= 8'h00;
         st_q.hit    <= 1'b0;
         st_q.bit_rd <= 1'b0;
         st_q.grant  <= 1'b0;
         st_q.block  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state record, register read data from the bank ram
   assign RD_DATA_O       = st_q.rdata;
   assign RD_HIT_O        = st_q.hit;
   assign BIT_RD_O        = st_q.bit_rd;
   assign REG_RD_DATA_O   = ram_rdata;
   assign ACC_O           = st_q.acc;
   assign B_O             = st_q.b;
   assign PSW_O           = psw_now;
   // RQ5: bank select drive
   assign BANK_SEL_O      = st_q.rs;
   assign DPTR_O          = {st_q.data_pointer_high, st_q.data_pointer_low};
   assign SP_O            = st_q.sp;
   // RQ8: baud doubling control
   assign BAUD_DOUBLE_O   = st_q.power_control[POWER_CONTROL_BAUD2];
   // RQ12: enhanced uart select
   assign UART_ENH_O      = st_q.cfg[CFG_UART_ENH];
   // RQ13: spi owns pins when set
   assign SYNC_PORT_SPI_O = st_q.cfg[CFG_SYNC_SEL];
   // RQ14: modulation gate out; pin choice lives elsewhere
   assign IR_MOD_EN_O     = st_q.cfg[CFG_IR_MOD];
   // RQ15: either bit enables
   assign XRAM_EN_O       = st_q.xram_en;
   assign XMOVE_GRANT_O   = st_q.grant;
   assign XMOVE_BLOCK_O   = st_q.block;
endmodule // mcsb_core_sfr
`default_nettype wire

// ==== verilog/mcsb_core_sfr_tail.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/mcsb_core_sfr_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsb_core_sfr_properties (
   input wire logic                      CLK_SYS_I,
   input wire logic                      SRST_I,
   input wire mcsb_pkg::mcsb_sfr_req_t   SFR_REQ_I,
   input wire mcsb_pkg::mcsb_bit_req_t   BIT_REQ_I,
   input wire mcsb_pkg::mcsb_alu_flags_t ALU_FLAGS_I,
   input wire logic                      XMOVE_REQ_I,
   input wire logic [7:0]                RD_DATA_O,
   input wire logic                      RD_HIT_O,
   input wire logic [7:0]                ACC_O,
   input wire logic [7:0]                PSW_O,
   input wire logic [1:0]                BANK_SEL_O,
   input wire logic [15:0]               DPTR_O,
   input wire logic [7:0]                SP_O,
   input wire logic                      BAUD_DOUBLE_O,
   input wire logic                      UART_ENH_O,
   input wire logic                      SYNC_PORT_SPI_O,
   input wire logic                      IR_MOD_EN_O,
   input wire logic                      XRAM_EN_O,
   input wire logic                      XMOVE_GRANT_O,
   input wire logic                      XMOVE_BLOCK_O
);
   import mcsb_pkg::*;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   logic       sw_wr;
   logic [7:0] wd_q;
   // software writes may legally move any status bit
   assign sw_wr = SFR_REQ_I.wr | BIT_REQ_I.wr;
   // write data kept so the decode check can slice it
   always_ff @(posedge CLK_SYS_I) begin
      wd_q <= SFR_REQ_I.wdata;
   end
   sequence s_acc_rd;
      SFR_REQ_I.rd && SFR_REQ_I.direct && SFR_REQ_I.addr == ADDR_ACC;
   endsequence
   sequence s_acc_hit;
      RD_HIT_O && RD_DATA_O == $past(ACC_O);
   endsequence
   a_acc_read_hit: assert property (s_acc_rd |=> s_acc_hit)
      else $error("accumulator read not answered");
   a_low_read_miss: assert property (SFR_REQ_I.rd &&
      (!SFR_REQ_I.direct || SFR_REQ_I.addr < SFR_BASE_ADDR) |=> !RD_HIT_O)
      else $error("indirect or low read hit an sfr");
   a_parity_even: assert property (PSW_O[PSW_P] == ^ACC_O)
      else $error("parity bit not even");
   a_bank_follow: assert property (BANK_SEL_O == PSW_O[4:3])
      else $error("bank select differs from status");
   a_flag_load: assert property (ALU_FLAGS_I.cls inside
      {ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV} |=>
      PSW_O[7] == $past(ALU_FLAGS_I.cy) && PSW_O[2] == $past(ALU_FLAGS_I.ov))
      else $error("carry or overflow not loaded");
   a_half_hold: assert property (!sw_wr && ALU_FLAGS_I.cls inside
      {ALU_SUBB, ALU_MUL, ALU_DIV} |=> $stable(PSW_O[6]))
      else $error("half carry moved by wrong class");
   a_user_keep: assert property (!sw_wr |=>
      $stable(PSW_O[5]) && $stable(PSW_O[1]))
      else $error("user flag changed without write");
   a_cfg_decode: assert property (SFR_REQ_I.wr && SFR_REQ_I.direct &&
      SFR_REQ_I.addr == ADDR_CFG |=> {UART_ENH_O, SYNC_PORT_SPI_O,
      IR_MOD_EN_O, XRAM_EN_O} == {wd_q[6:4], |wd_q[1:0]})
      else $error("configuration outputs wrong");
   a_baud_follow: assert property (SFR_REQ_I.wr && SFR_REQ_I.direct &&
      SFR_REQ_I.addr == ADDR_POWER_CONTROL |=> BAUD_DOUBLE_O == wd_q[POWER_CONTROL_BAUD2])
      else $error("baud doubling not stored");
   a_xmove_answer: assert property (XMOVE_REQ_I |=>
      XMOVE_GRANT_O == $past(XRAM_EN_O) && XMOVE_BLOCK_O == !$past(XRAM_EN_O))
      else $error("external move answer wrong");
   a_reset_load: assert property ($fell(SRST_I) |-> SP_O == RST_SP &&
      DPTR_O == 16'h0000 && !BAUD_DOUBLE_O)
      else $error("reset values wrong");
endmodule // mcsb_core_sfr_properties
bind mcsb_core_sfr mcsb_core_sfr_properties u_props (.CLK_SYS_I, .SRST_I,
   .SFR_REQ_I, .BIT_REQ_I, .ALU_FLAGS_I, .XMOVE_REQ_I, .RD_DATA_O, .RD_HIT_O,
   .ACC_O, .PSW_O, .BANK_SEL_O, .DPTR_O, .SP_O, .BAUD_DOUBLE_O, .UART_ENH_O,
   .SYNC_PORT_SPI_O, .IR_MOD_EN_O, .XRAM_EN_O, .XMOVE_GRANT_O,
   .XMOVE_BLOCK_O);
`default_nettype wire

// ==== verification/mcsb_core_sfr_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsb_core_sfr_test;
   import mcsb_pkg::*;
   logic            clk = 1'b0;
   logic            srst = 1'b1;
   mcsb_sfr_req_t   sfr = '0;
   mcsb_reg_req_t   rreq = '0;
   mcsb_alu_flags_t alu = '0;
   logic [5:0]      misc = '0;
   logic [7:0]      awd = '0;
   logic [15:0]     dwd = '0;
   logic [7:0]      rd_data, reg_rd;
   logic            rd_hit, rd_p = 1'b0, rg_p = 1'b0, mv_p = 1'b0;
   logic [1:0]      mv;
   logic [1:0]      mvq [$];
   logic [8:0]      rdq [$];
   logic [7:0]      rgq [$];
   logic [31:0]     seed = 32'h00000FC6;
   logic [7:0]      tbl [4] = '{ADDR_SP, ADDR_DPL, ADDR_DPH, ADDR_B};
   int              fails = 0;
   int              samples_checked = 0;
   // misc bits: acc we, sp inc, sp dec, dptr inc, dptr load, move request
   mcsb_core_sfr uut (.CLK_SYS_I(clk), .SRST_I(srst), .SFR_REQ_I(sfr),
      .BIT_REQ_I('0), .ALU_FLAGS_I(alu), .REG_REQ_I(rreq),
      .ACC_WE_I(misc[5]), .ACC_WD_I(awd), .SP_INC_I(misc[4]),
      .SP_DEC_I(misc[3]), .DPTR_INC_I(misc[2]), .DPTR_LD_I(misc[1]),
      .DPTR_WD_I(dwd), .XMOVE_REQ_I(misc[0]), .RD_DATA_O(rd_data),
      .RD_HIT_O(rd_hit), .BIT_RD_O(), .REG_RD_DATA_O(reg_rd), .ACC_O(),
      .B_O(), .PSW_O(), .BANK_SEL_O(), .DPTR_O(), .SP_O(), .BAUD_DOUBLE_O(),
      .UART_ENH_O(), .SYNC_PORT_SPI_O(), .IR_MOD_EN_O(), .XRAM_EN_O(),
      .XMOVE_GRANT_O(mv[1]), .XMOVE_BLOCK_O(mv[0]));
   // free running core clock
   always #50 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic close_out();
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_mv(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one cycle of every request at once, so no signal is driven twice
   task automatic step(input mcsb_sfr_req_t s, input mcsb_reg_req_t r,
                       input mcsb_alu_flags_t f, input logic [5:0] m);
      sfr <= s;
      rreq <= r;
      alu <= f;
      misc <= m;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step('{1'b1, 1'b0, 1'b1, a, d}, '0, '0, 6'h00);
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      rdq.push_back(e);
      step('{1'b0, 1'b1, 1'b1, a, 8'h00}, '0, '0, 6'h00);
   endtask
   // answers land one cycle after the request; look mid-cycle when settled
   always @(negedge clk) begin
      if (rd_p) chk_rd({rd_hit, rd_data}, rdq.pop_front());
      if (rg_p) chk_reg(reg_rd, rgq.pop_front());
      if (mv_p) chk_mv(mv, mvq.pop_front());
      rd_p = sfr.rd;
      rg_p = rreq.rd;
      mv_p = misc[0];
   end
   // hang guard, far beyond the roughly 83 cycles the run needs
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      logic [7:0]  v, w, ac;
      logic [15:0] d;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(ADDR_SP, 9'h107);
      rd(ADDR_DPL, 9'h100);
      rd(ADDR_DPH, 9'h100);
      rd(ADDR_POWER_CONTROL, 9'h100);
      rd(8'h88, 9'h000);
      // indirect and low accesses never reach an sfr
      step('{1'b1, 1'b0, 1'b0, ADDR_ACC, 8'h5A}, '0, '0, 6'h00);
      rd(ADDR_ACC, 9'h100);
      rdq.push_back(9'h000);
      step('{1'b0, 1'b1, 1'b0, ADDR_ACC, 8'h00}, '0, '0, 6'h00);
      rd(8'h05, 9'h000);
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         wr(tbl[k], seed[7:0]);
         rd(tbl[k], {1'b1, seed[7:0]});
      end
      // software keeps the documented bit levels
      seed = xs(seed);
      wr(ADDR_POWER_CONTROL, {seed[7], 7'h00});
      rd(ADDR_POWER_CONTROL, {1'b1, seed[7], 7'h00});
      wr(ADDR_CFG, {1'b1, seed[14:8]});
      rd(ADDR_CFG, {2'b11, seed[14:8]});
      // every enable code, then a move request
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CFG, 8'h80 | 8'(k));
         mvq.push_back((k == 0) ? 2'b01 : 2'b10);
         step('0, '0, '0, 6'h01);
      end
      // write bit 0 is dropped, parity follows accumulator
      seed = xs(seed);
      v = seed[7:0];
      w = seed[15:8];
      wr(ADDR_ACC, v);
      wr(ADDR_PSW, w);
      rd(ADDR_PSW, {1'b1, w[7:1], ^v});
      ac = seed[23:16];
      awd <= ac;
      step('0, '0, '0, 6'h20);
      rd(ADDR_ACC, {1'b1, ac});
      rd(ADDR_PSW, {1'b1, w[7:1], ^ac});
      for (int k = 0; k < 7; k++) begin
         wr(ADDR_PSW, 8'h00);
         step('0, '0, '{mcsb_alu_cls_t'(k[2:0]), 1'b1, 1'b1, 1'b1}, 6'h00);
         v = 8'h00;
         v[7] = k inside {[1:5]};
         v[6] = k inside {[1:2]};
         v[2] = v[7];
         v[0] = ^ac;
         rd(ADDR_PSW, {1'b1, v});
      end
      // bank registers sit in the low 32 bytes
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         wr(8'(k * 8 + 3), seed[7:0]);
         wr(ADDR_PSW, {3'b000, k[1:0], 3'b000});
         rgq.push_back(seed[7:0]);
         step('0, '{1'b0, 1'b1, 3'd3, 8'h00}, '0, 6'h00);
      end
      seed = xs(seed);
      d = seed[31:16] + 16'h0001;
      dwd <= seed[31:16];
      step('0, '0, '0, 6'h02);
      step('0, '0, '0, 6'h04);
      rd(ADDR_DPL, {1'b1, d[7:0]});
      rd(ADDR_DPH, {1'b1, d[15:8]});
      wr(ADDR_SP, 8'hFF);
      step('0, '0, '0, 6'h10);
      rd(ADDR_SP, 9'h100);
      step('0, '0, '0, 6'h08);
      rd(ADDR_SP, 9'h1FF);
      step('0, '0, '0, 6'h00);
      @(posedge clk);
      close_out();
   end
endmodule // mcsb_core_sfr_test
`default_nettype wire
